/* File: logic/ms_resolve_pkg.sv */
// Purpose: constants and types for the leader/follower resolver
// Assumes: page 1 and page 2 bits arrive as plain same-clock inputs
// Notes: seed fields are 11 bits, msb is bit 10
// Operation
// - decide on entry to link good check
// - classify sides from page 1 bits
// - forced_leader > multiport > single > forced_follower
// - same single or multiport type: higher unsigned seed wins
// - equal seeds: new seed, link fail
// - success means resolution complete
// - seeds from the free-running lfsr, 1 to 2046, all-ones folded to 2046
// - seed counter cleared at start, counts seeds
// - completion clears counter, only success clears fault bit
// - fault after seventh seed unresolved
// - both forced same way is fault
// - fault completes but forces link fail
// - manual enable and value bits force role
// - success clears fault, sets role bit
// - role goes to phy control
// - only when gigabit is highest common ability
// - eleven bit seed, bit 10 msb
// - advertise port type bit
`default_nettype none
package ms_resolve_pkg;
  localparam int SEED_W         = 11;
  localparam int SEED_MSB       = 10;
  localparam int CNT_W          = 4;
  localparam logic [3:0] SEED_LIMIT = 4'h7;
  localparam logic [10:0] SEED_MAX  = 11'h7fe;
  localparam logic [10:0] LFSR_INIT = 11'h5a5;
  localparam int CFG_EN_POS     = 0;
  localparam int CFG_VAL_POS    = 1;
  localparam int PORT_TYPE_POS  = 2;

  typedef enum logic [1:0] {
    TYPE_FOLLOWER = 2'h0,
    TYPE_SINGLE   = 2'h1,
    TYPE_MULTI    = 2'h2,
    TYPE_LEADER   = 2'h3
  } dev_type_t;

  typedef struct packed {
    logic [2:0]        page1;
    logic [SEED_W-1:0] seed;
  } adv_t;
endpackage : ms_resolve_pkg
`default_nettype wire

/* File: logic/leader_follower_resolver.sv */
// Purpose: resolve local leader/follower timing role during auto-negotiation
// Assumes: check_entry is a one-cycle pulse from arbitration on the same clock
// Notes: outcome strobes come two cycles after check_entry
`default_nettype none
module leader_follower_resolver (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  check_entry,
  input  wire logic                  gig_is_highest_common_ability,
  input  wire logic                  manual_cfg_enable_bit,
  input  wire logic                  manual_cfg_value_bit,
  input  wire logic                  port_type_bit,
  input  wire ms_resolve_pkg::adv_t  remote_adv,
  output ms_resolve_pkg::adv_t       local_adv,
  output logic                       resolve_done,
  output logic                       resolve_fault,
  output logic                       link_restart,
  output logic                       gig_link_state_fail,
  output logic                       fault_status,
  output logic                       role_status,
  output logic                       phy_role_indication,
  output logic [3:0]                 seed_count
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_s2_r;

  // ****************************************
  // seed source
  // ****************************************
  logic [10:0] lfsr_r;
  logic [10:0] seed_r;
  logic        new_seed;
  // lfsr free runs so the draw point depends on link timing, decorrelating peers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_r <= ms_resolve_pkg::LFSR_INIT;
    end else begin
      lfsr_r <= {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]};
    end
  end

  // all-ones is folded down so the seed stays within 1..2046
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seed_r <= ms_resolve_pkg::LFSR_INIT;
    end else if (new_seed) begin
      seed_r <= (lfsr_r > ms_resolve_pkg::SEED_MAX) ? ms_resolve_pkg::SEED_MAX : lfsr_r;
    end
  end

  always_comb begin
    local_adv.page1 = {port_type_bit, manual_cfg_value_bit, manual_cfg_enable_bit};
    local_adv.seed  = seed_r;
  end

  // ****************************************
  // capture and classify
  // ****************************************
  ms_resolve_pkg::adv_t rem_r, loc_r;
  logic pend_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      rem_r  <= '0;
      loc_r  <= '0;
    end else begin
      pend_r <= check_entry && gig_is_highest_common_ability;
      if (check_entry) begin
        rem_r <= remote_adv;
        loc_r <= local_adv;
      end
    end
  end

  function automatic ms_resolve_pkg::dev_type_t classify(input logic [2:0] p);
    if (p[ms_resolve_pkg::CFG_EN_POS])
      classify = p[ms_resolve_pkg::CFG_VAL_POS] ? ms_resolve_pkg::TYPE_LEADER
                                                 : ms_resolve_pkg::TYPE_FOLLOWER;
    else
      classify = p[ms_resolve_pkg::PORT_TYPE_POS] ? ms_resolve_pkg::TYPE_MULTI
                                                   : ms_resolve_pkg::TYPE_SINGLE;
  endfunction

  ms_resolve_pkg::dev_type_t lt, rt;
  logic win, lose, cfg_fault, tie, cnt_fault;
  always_comb begin
    lt = classify(loc_r.page1);
    rt = classify(rem_r.page1);
    win = 1'b0;
    lose = 1'b0;
    cfg_fault = 1'b0;
    tie = 1'b0;
    if (lt > rt) win = 1'b1;
    else if (lt < rt) lose = 1'b1;
    else if (lt == ms_resolve_pkg::TYPE_LEADER || lt == ms_resolve_pkg::TYPE_FOLLOWER) cfg_fault = 1'b1;
    else if (loc_r.seed > rem_r.seed) win = 1'b1;
    else if (loc_r.seed < rem_r.seed) lose = 1'b1;
    else tie = 1'b1;
  end
  assign cnt_fault = tie && (seed_count >= ms_resolve_pkg::SEED_LIMIT);
  // a tie that hits the attempt limit ends in a fault, so no further seed is drawn
  assign new_seed  = pend_r && tie && !cnt_fault;

  // ****************************************
  // outcome
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resolve_done <= 1'b0;
    end else begin
      resolve_done <= pend_r && (win || lose || cfg_fault || cnt_fault);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resolve_fault <= 1'b0;
    end else begin
      resolve_fault <= pend_r && (cfg_fault || cnt_fault);
    end
  end

  // every fault also fails the link, the attempt-limit fault included
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_restart <= 1'b0;
    end else begin
      link_restart <= pend_r && (tie || cfg_fault);
    end
  end
  assign gig_link_state_fail = link_restart;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seed_count <= 4'h0;
    end else if (pend_r && (win || lose || cfg_fault || cnt_fault)) begin
      seed_count <= 4'h0;
    end else if (new_seed && seed_count != 4'hf) begin
      seed_count <= seed_count + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_status <= 1'b0;
      role_status  <= 1'b0;
    end else if (pend_r) begin
      if (cfg_fault || cnt_fault) fault_status <= 1'b1;
      else if (win || lose) begin
        fault_status <= 1'b0;
        role_status  <= win;
      end
    end
  end
  assign phy_role_indication = role_status;

  // ****************************************
  // checks
  // ****************************************
  a_done_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resolve_done |-> $past(check_entry, 2) && $past(gig_is_highest_common_ability, 2))
    else $error("done without check entry");
  a_no_gig_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    check_entry && !gig_is_highest_common_ability |-> ##2 !resolve_done && !link_restart)
    else $error("resolved without gigabit ability");
  a_fault_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resolve_fault |-> fault_status && resolve_done)
    else $error("fault strobe without status");
  a_success_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resolve_done && !resolve_fault |-> !fault_status && seed_count == 4'h0)
    else $error("success did not clear");
  a_tie_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    new_seed |=> link_restart && !resolve_done)
    else $error("tie did not restart");
  a_seed_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    new_seed && !cnt_fault |=> seed_count == $past(seed_count) + 4'h1)
    else $error("seed counter did not step");
  a_seed_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seed_r <= ms_resolve_pkg::SEED_MAX)
    else $error("seed out of range");
  a_role_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend_r && win && !cfg_fault |=> role_status && phy_role_indication)
    else $error("winner not leader");
  a_seventh: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend_r && tie && seed_count == 4'h7 |=> resolve_fault && fault_status)
    else $error("no fault after seventh seed");

  // ****************************************
  // outcome steps
  // ****************************************
  sequence s_entry_gig;
    check_entry && gig_is_highest_common_ability;
  endsequence

  sequence s_pend_win;
    pend_r && win;
  endsequence

  sequence s_pend_lose;
    pend_r && lose;
  endsequence

  sequence s_pend_cfg;
    pend_r && cfg_fault;
  endsequence

  sequence s_pend_cnt;
    pend_r && cnt_fault;
  endsequence

  sequence s_pend_tie;
    pend_r && tie && !cnt_fault;
  endsequence

  sequence s_pend_any;
    pend_r && (win || lose || cfg_fault || cnt_fault);
  endsequence

  a_entry_pend: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_entry_gig
    |=> pend_r)
    else $error("entry not taken");

  a_entry_no_gig: assert property (@(posedge sys_clk) disable iff (!rst_n)
    check_entry && !gig_is_highest_common_ability
    |=> !pend_r)
    else $error("entry taken without gigabit ability");

  a_win_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_win
    |=> resolve_done && !resolve_fault && !link_restart)
    else $error("win strobes wrong");

  a_win_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_win
    |=> !fault_status && seed_count == 4'h0)
    else $error("win did not clear status");

  a_win_indicate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_win
    |=> phy_role_indication)
    else $error("leader role not passed on");

  a_lose_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_lose
    |=> resolve_done && !resolve_fault && !link_restart)
    else $error("lose strobes wrong");

  a_lose_role: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_lose
    |=> !role_status && !phy_role_indication)
    else $error("loser not follower");

  a_lose_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_lose
    |=> !fault_status && seed_count == 4'h0)
    else $error("lose did not clear status");

  a_cfg_outcome: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_cfg
    |=> resolve_done && resolve_fault && link_restart)
    else $error("forced clash strobes wrong");

  a_cfg_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_cfg
    |=> fault_status && seed_count == 4'h0)
    else $error("forced clash status wrong");

  a_cnt_outcome: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_cnt
    |=> resolve_done && resolve_fault && gig_link_state_fail)
    else $error("attempt limit strobes wrong");

  a_cnt_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_cnt
    |=> seed_count == 4'h0)
    else $error("attempt limit did not clear counter");

  a_tie_no_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_tie
    |=> !resolve_done && !resolve_fault && gig_link_state_fail)
    else $error("tie strobes wrong");

  a_tie_counted: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_tie
    |=> seed_count != 4'h0)
    else $error("tie not counted");

  a_any_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pend_any
    |=> resolve_done)
    else $error("resolution not completed");

  a_status_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pend_r
    |=> $stable(fault_status) && $stable(role_status))
    else $error("status moved without decision");

  a_count_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pend_r
    |=> $stable(seed_count))
    else $error("counter moved without decision");

  a_seed_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !new_seed
    |=> $stable(seed_r))
    else $error("seed moved without a tie");

  a_count_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seed_count <= ms_resolve_pkg::SEED_LIMIT)
    else $error("counter past attempt limit");

  a_quiet_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pend_r
    |=> !resolve_done && !resolve_fault && !link_restart)
    else $error("strobe without pending decision");

  a_done_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resolve_done
    |=> !resolve_done)
    else $error("done strobe too long");

  a_restart_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    link_restart
    |=> !link_restart)
    else $error("restart strobe too long");

  a_restart_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    link_restart
    |-> $past(pend_r) && ($past(tie) || $past(cfg_fault)))
    else $error("restart without tie or fault");

  a_manual_leader: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend_r && lt == ms_resolve_pkg::TYPE_LEADER && rt != ms_resolve_pkg::TYPE_LEADER
    |=> role_status && resolve_done)
    else $error("forced leader not leader");

  a_manual_follower: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend_r && lt == ms_resolve_pkg::TYPE_FOLLOWER && rt != ms_resolve_pkg::TYPE_FOLLOWER
    |=> !role_status && resolve_done)
    else $error("forced follower not follower");

endmodule // leader_follower_resolver
`default_nettype wire

/* File: verification/remote_phy_model.sv */
// Purpose: far side advertisement as the resolver captures it
// Assumes: bench picks the far side type and seed
// Notes: combinational, a captured page needs no timing
`default_nettype none
module remote_phy_model (
  input  wire ms_resolve_pkg::dev_type_t dtype,
  input  wire logic [10:0]               seed,
  output ms_resolve_pkg::adv_t           adv
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    adv.seed  = seed;
    adv.page1 = {dtype == ms_resolve_pkg::TYPE_MULTI, dtype == ms_resolve_pkg::TYPE_LEADER,
                 dtype inside {ms_resolve_pkg::TYPE_LEADER, ms_resolve_pkg::TYPE_FOLLOWER}};
  end
endmodule // remote_phy_model
`default_nettype wire

/* File: verification/leader_follower_resolver_tb.sv */
// Purpose: self-checking bench for the role resolver
// Assumes: strobes two edges after check_entry
// Notes: local seed is read to aim remote seeds and to predict the role
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module leader_follower_resolver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // stimulus and scoreboard
  // ****
  logic                      sys_clk = 1'b0;
  logic                      resetn = 1'b0;
  logic                      check_entry = 1'b0;
  logic                      gig_ok = 1'b1;
  ms_resolve_pkg::dev_type_t ltype = ms_resolve_pkg::TYPE_SINGLE;
  ms_resolve_pkg::dev_type_t rtype = ms_resolve_pkg::TYPE_SINGLE;
  logic [10:0]               rseed = 11'h000;
  ms_resolve_pkg::adv_t      remote_adv, local_adv, local_cfg;
  logic                      resolve_done, resolve_fault, link_restart, gig_link_state_fail;
  logic                      fault_status, role_status, phy_role_indication, fst = 1'b0;
  logic [3:0]                seed_count, cnt = 4'h0;
  logic [10:0]               q[$];
  logic [10:0]               e;
  int                        checks = 0;
  int                        mismatches = 0;
  always #50 sys_clk = ~sys_clk;
  remote_phy_model remote_phy_model_inst (.dtype(rtype), .seed(rseed), .adv(remote_adv));
  // same encoder gives the local control bits
  remote_phy_model local_cfg_inst (.dtype(ltype), .seed(11'h000), .adv(local_cfg));
  leader_follower_resolver leader_follower_resolver_inst (
    .sys_clk(sys_clk), .resetn(resetn), .check_entry(check_entry),
    .gig_is_highest_common_ability(gig_ok), .manual_cfg_enable_bit(local_cfg.page1[0]),
    .manual_cfg_value_bit(local_cfg.page1[1]), .port_type_bit(local_cfg.page1[2]),
    .remote_adv(remote_adv), .local_adv(local_adv), .resolve_done(resolve_done),
    .resolve_fault(resolve_fault), .link_restart(link_restart), .gig_link_state_fail(gig_link_state_fail),
    .fault_status(fault_status), .role_status(role_status), .phy_role_indication(phy_role_indication),
    .seed_count(seed_count));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // enum order equals leader priority, so a plain compare ranks types
  task automatic go(input int l, input int r, input bit tie, input bit gig);
    logic [10:0] s;
    logic        role;
    s = tie ? local_adv.seed : 11'($urandom % 2047);
    if (!tie && s == local_adv.seed) s = s ^ 11'h001;
    role = (l > r) || (l == r && local_adv.seed > s);
    if (!gig) begin
    end else if (l == r && (l == 0 || l == 3)) begin
      fst = 1'b1; cnt = 4'h0; q.push_back({1'b0, 5'b11111, 1'b0, 4'h0});
    end else if (tie && cnt >= 4'h7) begin
      fst = 1'b1; cnt = 4'h0; q.push_back({1'b0, 5'b11111, 1'b0, 4'h0});
    end else if (tie) begin
      cnt++; q.push_back({1'b0, 4'b0011, fst, 1'b0, cnt});
    end else begin
      fst = 1'b0; cnt = 4'h0; q.push_back({1'b1, 5'b10000, role, 4'h0});
    end
    @(posedge sys_clk);
    ltype <= ms_resolve_pkg::dev_type_t'(l);
    rtype <= ms_resolve_pkg::dev_type_t'(r);
    rseed <= s;
    gig_ok <= gig;
    check_entry <= 1'b1;
    @(posedge sys_clk);
    check_entry <= 1'b0;
    gig_ok <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (resetn && (resolve_done | resolve_fault | link_restart)) begin
      if (q.size() == 0) `CHK("unexpected strobe", 1'b0, 1'b1)
      else begin
        e = q.pop_front();
        `CHK("outcome", e[9:5], {resolve_done, resolve_fault, link_restart, gig_link_state_fail, fault_status})
        `CHK("seed count", e[3:0], seed_count)
        if (e[10]) `CHK("role", {2{e[4]}}, {role_status, phy_role_indication})
      end
    end
  end
  initial begin
    void'($urandom(32'he494ecd5));
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    for (int l = 0; l < 4; l++) for (int r = 0; r < 4; r++) go(l, r, 1'b0, 1'b1);
    $display("test type table done");
    for (int i = 0; i < 8; i++) go(1, 1, 1'b1, 1'b1);
    go(2, 2, 1'b0, 1'b1);
    $display("test seed ties done");
    go(3, 3, 1'b0, 1'b0);
    go(1, 1, 1'b1, 1'b0);
    $display("test other ability done");
    for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge sys_clk);
    if (q.size() != 0) `CHK("pending outcomes", 0, q.size())
    give_verdict();
  end
endmodule // leader_follower_resolver_tb
`default_nettype wire
